// File: src/agpsp_pkg.sv
// shared constants and types for the graphics port status/pipe link
package agpsp_pkg;

  localparam int AD_W   = 32;
  localparam int HALF_W = 16;
  localparam int ST_W   = 3;
  localparam int STB_W  = 2;

  // status bus codes, meaningful only under grant
  localparam logic [ST_W-1:0] ST_LP_READ  = 3'h0;
  localparam logic [ST_W-1:0] ST_HP_READ  = 3'h1;
  localparam logic [ST_W-1:0] ST_LP_WRITE = 3'h2;
  localparam logic [ST_W-1:0] ST_HP_WRITE = 3'h3;
  localparam logic [ST_W-1:0] ST_OWNER    = 3'h7;
  localparam logic [ST_W-1:0] ST_IDLE_VAL = 3'h7;

  localparam logic [AD_W-1:0]  AD_RST  = 32'h0;
  localparam logic [STB_W-1:0] STB_RST = 2'h0;

  // link clock made by the core-logic end from clk_sys
  localparam int SYS_PERIOD_NS    = 8;
  localparam int LINK_PERIOD_NS   = 48;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

  // link ticks of pipe high that end an ownership tenure at the core logic
  localparam logic [1:0] OWN_IDLE_TICKS = 2'h3;

  typedef enum logic [2:0] {
    AGPSP_D_IDLE = 3'b001,
    AGPSP_D_PIPE = 3'b010,
    AGPSP_D_END  = 3'b100
  } agpsp_dstate_t;

  typedef enum logic [3:0] {
    AGPSP_H_IDLE = 4'b0001,
    AGPSP_H_RD   = 4'b0010,
    AGPSP_H_WR   = 4'b0100,
    AGPSP_H_OWN  = 4'b1000
  } agpsp_hstate_t;

endpackage

// File: src/agpsp_if.sv
// link between the graphics master end and the core-logic end
`timescale 1ns/1ps
interface agpsp_if;
  import agpsp_pkg::*;

  logic              agp_clk;
  logic [ST_W-1:0]   st;
  logic              gnt_n;
  logic              rbf_n;
  logic              req_n;
  logic              pipe_o;
  logic              pipe_oe;
  logic              pipe_n;
  logic [AD_W-1:0]   ad_dev_o;
  logic              ad_dev_oe;
  logic [AD_W-1:0]   ad_host_o;
  logic              ad_host_oe;
  logic [AD_W-1:0]   ad;
  logic [STB_W-1:0]  stb_dev_o;
  logic              stb_dev_oe;
  logic [STB_W-1:0]  stb_host_o;
  logic              stb_host_oe;
  logic [STB_W-1:0]  stb;

  // board resolution: pipe and ad pulled up, strobes pulled down
  assign pipe_n = pipe_oe ? pipe_o : 1'b1;
  assign ad     = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : {AD_W{1'b1}});
  assign stb    = stb_dev_oe ? stb_dev_o : (stb_host_oe ? stb_host_o : STB_RST);

  modport dev (
    input  agp_clk, st, gnt_n, ad, stb,
    output rbf_n, req_n, pipe_o, pipe_oe, ad_dev_o, ad_dev_oe, stb_dev_o, stb_dev_oe
  );

  modport host (
    output agp_clk, st, gnt_n, ad_host_o, ad_host_oe, stb_host_o, stb_host_oe,
    input  rbf_n, req_n, pipe_n, ad, stb
  );
endinterface

// File: src/agpsp_clk_div.sv
// link clock divider with a tick on the falling edge
`timescale 1ns/1ps
module agpsp_clk_div #(
  parameter int HALF = agpsp_pkg::LINK_HALF_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      clk_o,
  output logic      tick
);
  import agpsp_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
  } agpsp_div_t;

  agpsp_div_t s;
  agpsp_div_t next_s;

  always_comb begin
    next_s = s;
    if (s.cnt == 8'(2 * HALF - 1)) begin
      next_s.cnt = 8'h0;
    end else begin
      next_s.cnt = s.cnt + 8'h1;
    end
    next_s.clk = (next_s.cnt < 8'(HALF));
    if (rst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
  end

  assign clk_o = s.clk;
  // link outputs change mid-period, away from the receiving rising edge
  assign tick  = (s.cnt == 8'(HALF - 1));
endmodule

// File: src/agpsp_dev.sv
// graphics master end: status decode, read-buffer-full and pipelined requests
// Function
// - act on status only while grant asserted
// - code 000: accept low priority read data
// - code 001: accept high priority read data
// - code 010: drive low priority write data
// - code 011: drive high priority write data
// - ownership: begin by enqueuing with pipe
// - status bus is input only, core drives
// - drive rbf low when read buffer full
// - core withholds low priority reads under rbf
// - pipe only while current bus master
// - one request per edge with pipe asserted
// - no request enqueued while pipe deasserted
// - drive pipe high before releasing it
// - strobe 0 low half, strobe 1 high half
// - data source drives both strobes
`timescale 1ns/1ps
module agpsp_dev (
  input  wire logic             agp_clk,
  input  wire logic             rst,
  agpsp_if.dev                  link,
  input  wire logic             req_valid,
  input  wire logic [31:0]      req_addr,
  output logic                  req_ready,
  input  wire logic             rd_buf_full,
  output logic [31:0]           rd_data,
  output logic                  rd_valid,
  output logic                  rd_hi,
  input  wire logic [31:0]      wr_lo_data,
  input  wire logic [31:0]      wr_hi_data,
  output logic                  wr_taken,
  output logic                  wr_taken_hi,
  output logic                  owner,
  output logic                  rsvd_seen
);
  import agpsp_pkg::*;

  typedef struct packed {
    logic                 rst_meta;
    logic                 rst_sync;
    agpsp_dstate_t        state;
    logic                 req_n;
    logic                 rbf_n;
    logic                 pipe_o;
    logic                 pipe_oe;
    logic [AD_W-1:0]      ad_o;
    logic                 ad_oe;
    logic [STB_W-1:0]     stb_o;
    logic                 stb_oe;
    logic                 req_ready;
    logic [AD_W-1:0]      rd_data;
    logic                 rd_valid;
    logic                 rd_hi;
    logic                 wr_taken;
    logic                 wr_hi;
    logic                 owner;
    logic                 rsvd_seen;
  } agpsp_dev_t;

  agpsp_dev_t s;
  agpsp_dev_t next_s;

  logic granted;
  logic rd_code;
  logic wr_code;
  logic [STB_W-1:0] halves;
  logic own_code;
  logic rsvd_code;

  // status is sampled, never driven
  assign granted = !link.gnt_n;
  assign rd_code = (link.st == ST_LP_READ) || (link.st == ST_HP_READ);
  assign wr_code = (link.st == ST_LP_WRITE) || (link.st == ST_HP_WRITE);
  assign halves  = link.stb;
  assign own_code  = (link.st == ST_OWNER);
  // anything not read, write or ownership is a reserved code
  assign rsvd_code = !rd_code && !wr_code && !own_code;

  always_comb begin
    next_s = s;
    // reset crosses from the system domain through two stages
    next_s.rst_meta = rst;
    next_s.rst_sync = s.rst_meta;

    next_s.rd_valid  = 1'b0;
    next_s.wr_taken  = 1'b0;
    next_s.rsvd_seen = 1'b0;
    next_s.stb_oe    = 1'b0;
    next_s.stb_o     = STB_RST;
    // read data is still taken when full: the host is the one that honours rbf
    next_s.rbf_n     = !rd_buf_full;

    // read return: each half is taken on its own strobe
    if (granted && rd_code && s.state == AGPSP_D_IDLE) begin
      for (int h = 0; h < STB_W; h++) begin
        if (halves[h]) begin
          next_s.rd_data[h*HALF_W +: HALF_W] = link.ad[h*HALF_W +: HALF_W];
        end
      end
      next_s.rd_valid = (halves == 2'h3);
      next_s.rd_hi    = (link.st == ST_HP_READ);
    end

    // grants seen outside idle are dropped; the host never issues them mid-tenure
    case (s.state)
      AGPSP_D_IDLE: begin
        next_s.ad_oe   = 1'b0;
        next_s.pipe_oe = 1'b0;
        next_s.owner   = 1'b0;
        next_s.req_n   = !req_valid;
        if (granted) begin
          if (wr_code) begin
            // write data goes out for one period with both strobes
            next_s.ad_o     = (link.st == ST_HP_WRITE) ? wr_hi_data : wr_lo_data;
            next_s.ad_oe    = 1'b1;
            next_s.stb_o    = 2'h3;
            next_s.stb_oe   = 1'b1;
            next_s.wr_taken = 1'b1;
            next_s.wr_hi    = (link.st == ST_HP_WRITE);
          end else if (own_code) begin
            if (req_valid) begin
              // first period drives pipe deasserted, requests follow
              next_s.state     = AGPSP_D_PIPE;
              next_s.owner     = 1'b1;
              next_s.pipe_oe   = 1'b1;
              next_s.pipe_o    = 1'b1;
              next_s.req_ready = 1'b1;
              next_s.req_n     = 1'b1;
            end
          end else if (rsvd_code) begin
            next_s.rsvd_seen = 1'b1;
          end
        end
      end
      AGPSP_D_PIPE: begin
        next_s.req_n = 1'b1;
        if (req_valid && s.req_ready) begin
          // one address per rising edge while pipe is low
          next_s.pipe_o = 1'b0;
          next_s.ad_o   = req_addr;
          next_s.ad_oe  = 1'b1;
        end else begin
          // queue drained: deassert pipe and free the bus
          next_s.pipe_o    = 1'b1;
          next_s.ad_oe     = 1'b0;
          next_s.req_ready = 1'b0;
          next_s.state     = AGPSP_D_END;
        end
      end
      AGPSP_D_END: begin
        // pipe was driven high for a full period, now release it
        next_s.pipe_oe = 1'b0;
        next_s.owner   = 1'b0;
        next_s.state   = AGPSP_D_IDLE;
      end
      default: begin
        next_s.state = AGPSP_D_IDLE;
      end
    endcase

    // link stays quiet until reset has crossed both stages
    if (s.rst_sync) begin
      next_s.state     = AGPSP_D_IDLE;
      next_s.req_n     = 1'b1;
      next_s.rbf_n     = 1'b1;
      next_s.pipe_o    = 1'b1;
      next_s.pipe_oe   = 1'b0;
      next_s.ad_o      = AD_RST;
      next_s.ad_oe     = 1'b0;
      next_s.stb_o     = STB_RST;
      next_s.stb_oe    = 1'b0;
      next_s.req_ready = 1'b0;
      next_s.rd_data   = AD_RST;
      next_s.rd_valid  = 1'b0;
      next_s.rd_hi     = 1'b0;
      next_s.wr_taken  = 1'b0;
      next_s.wr_hi     = 1'b0;
      next_s.owner     = 1'b0;
      next_s.rsvd_seen = 1'b0;
    end
  end

  always_ff @(posedge agp_clk) begin
    s <= next_s;
  end

  assign link.req_n      = s.req_n;
  assign link.rbf_n      = s.rbf_n;
  assign link.pipe_o     = s.pipe_o;
  assign link.pipe_oe    = s.pipe_oe;
  assign link.ad_dev_o   = s.ad_o;
  assign link.ad_dev_oe  = s.ad_oe;
  assign link.stb_dev_o  = s.stb_o;
  assign link.stb_dev_oe = s.stb_oe;

  assign req_ready   = s.req_ready;
  assign rd_data     = s.rd_data;
  assign rd_valid    = s.rd_valid;
  assign rd_hi       = s.rd_hi;
  assign wr_taken    = s.wr_taken;
  assign wr_taken_hi = s.wr_hi;
  assign owner       = s.owner;
  assign rsvd_seen   = s.rsvd_seen;
endmodule

// File: src/agpsp_host.sv
// core-logic end: arbiter driving status, read returns and request capture
`timescale 1ns/1ps
module agpsp_host (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  agpsp_if.host                 link,
  input  wire logic             rd_ret_valid,
  input  wire logic             rd_ret_hi,
  input  wire logic [31:0]      rd_ret_data,
  output logic                  rd_ret_take,
  input  wire logic             wr_pend_valid,
  input  wire logic             wr_pend_hi,
  output logic                  wr_pend_take,
  output logic [31:0]           wr_data,
  output logic                  wr_data_valid,
  output logic                  wr_data_hi,
  output logic [31:0]           enq_addr,
  output logic                  enq_valid,
  output logic                  dev_rbf
);
  import agpsp_pkg::*;

  typedef struct packed {
    agpsp_hstate_t     state;
    logic              gnt_n;
    logic [ST_W-1:0]   st;
    logic [AD_W-1:0]   ad_o;
    logic              ad_oe;
    logic [STB_W-1:0]  stb_o;
    logic              stb_oe;
    logic [1:0]        own_cnt;
    logic              rd_take;
    logic              wr_take;
    logic              wr_hi;
    logic [AD_W-1:0]   wr_data;
    logic              wr_valid;
    logic [AD_W-1:0]   enq_addr;
    logic              enq_valid;
    logic              dev_rbf;
  } agpsp_host_t;

  agpsp_host_t s;
  agpsp_host_t next_s;
  logic        tick;

  agpsp_clk_div #(
    .HALF (LINK_HALF_CYCLES)
  ) u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_o   (link.agp_clk),
    .tick    (tick)
  );

  always_comb begin
    next_s = s;
    next_s.rd_take   = 1'b0;
    next_s.wr_take   = 1'b0;
    next_s.wr_valid  = 1'b0;
    next_s.enq_valid = 1'b0;
    if (tick) begin
      next_s.dev_rbf = !link.rbf_n;
      next_s.gnt_n   = 1'b1;
      next_s.st      = ST_IDLE_VAL;
      next_s.ad_oe   = 1'b0;
      next_s.stb_oe  = 1'b0;
      next_s.stb_o   = STB_RST;
      case (s.state)
        AGPSP_H_IDLE: begin
          // high priority returns ignore the buffer-full flag
          if (rd_ret_valid && (rd_ret_hi || link.rbf_n)) begin
            next_s.gnt_n   = 1'b0;
            next_s.st      = rd_ret_hi ? ST_HP_READ : ST_LP_READ;
            next_s.ad_o    = rd_ret_data;
            next_s.ad_oe   = 1'b1;
            next_s.stb_o   = 2'h3;
            next_s.stb_oe  = 1'b1;
            next_s.rd_take = 1'b1;
            next_s.state   = AGPSP_H_RD;
          end else if (wr_pend_valid) begin
            next_s.gnt_n   = 1'b0;
            next_s.st      = wr_pend_hi ? ST_HP_WRITE : ST_LP_WRITE;
            next_s.wr_hi   = wr_pend_hi;
            next_s.wr_take = 1'b1;
            next_s.state   = AGPSP_H_WR;
          end else if (!link.req_n) begin
            next_s.gnt_n   = 1'b0;
            next_s.st      = ST_OWNER;
            next_s.own_cnt = 2'h0;
            next_s.state   = AGPSP_H_OWN;
          end
        end
        AGPSP_H_RD: begin
          next_s.state = AGPSP_H_IDLE;
        end
        AGPSP_H_WR: begin
          next_s.wr_data  = link.ad;
          next_s.wr_valid = (link.stb == 2'h3);
          next_s.state    = AGPSP_H_IDLE;
        end
        AGPSP_H_OWN: begin
          // a request is taken only on a period with pipe low
          if (!link.pipe_n) begin
            next_s.enq_addr  = link.ad;
            next_s.enq_valid = 1'b1;
            next_s.own_cnt   = 2'h0;
          end else if (s.own_cnt == OWN_IDLE_TICKS - 2'h1) begin
            next_s.state = AGPSP_H_IDLE;
          end else begin
            next_s.own_cnt = s.own_cnt + 2'h1;
          end
        end
        default: begin
          next_s.state = AGPSP_H_IDLE;
        end
      endcase
    end
    if (rst) begin
      next_s = '0;
      next_s.state = AGPSP_H_IDLE;
      next_s.gnt_n = 1'b1;
      next_s.st    = ST_IDLE_VAL;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
  end

  assign link.gnt_n       = s.gnt_n;
  assign link.st          = s.st;
  assign link.ad_host_o   = s.ad_o;
  assign link.ad_host_oe  = s.ad_oe;
  assign link.stb_host_o  = s.stb_o;
  assign link.stb_host_oe = s.stb_oe;

  assign rd_ret_take   = s.rd_take;
  assign wr_pend_take  = s.wr_take;
  assign wr_data       = s.wr_data;
  assign wr_data_valid = s.wr_valid;
  assign wr_data_hi    = s.wr_hi;
  assign enq_addr      = s.enq_addr;
  assign enq_valid     = s.enq_valid;
  assign dev_rbf       = s.dev_rbf;
endmodule

// File: verif/agpsp_checker.sv
// assertions on the link between the two ends
`timescale 1ns/1ps
module agpsp_checker (
  input wire logic       agp_clk,
  input wire logic       rst,
  input wire logic [2:0] st,
  input wire logic       gnt_n,
  input wire logic       rbf_n,
  input wire logic       pipe_o,
  input wire logic       pipe_oe,
  input wire logic       ad_dev_oe,
  input wire logic       ad_host_oe,
  input wire logic       stb_dev_oe,
  input wire logic [1:0] stb_dev_o,
  input wire logic [1:0] stb
);
  default clocking @(posedge agp_clk); endclocking
  default disable iff (rst);
  a_pipe_owner:
    assert property ($rose(pipe_oe) |-> !$past(gnt_n) && $past(st) == 3'h7) else $error("pipe w/o grant");
  a_own_start:
    assert property (!gnt_n && st == 3'h7 |=> pipe_oe) else $error("no pipe after ownership");
  a_pipe_release:
    assert property ($fell(pipe_oe) |-> $past(pipe_o)) else $error("pipe released while low");
  a_pipe_addr:
    assert property (pipe_oe && !pipe_o |-> ad_dev_oe && !ad_host_oe) else $error("pipe w/o address");
  a_wr_answer:
    assert property (!gnt_n && st[2:1] == 2'b01 |=> ad_dev_oe && stb_dev_oe && stb_dev_o == 2'h3)
      else $error("write data not driven");
  a_wr_hold:
    assert property ($rose(ad_dev_oe) && !pipe_oe |=> !ad_dev_oe) else $error("write data overstays");
  a_rd_strobes:
    assert property (!gnt_n && st[2:1] == 2'b00 |-> ad_host_oe && stb == 2'h3 && !stb_dev_oe)
      else $error("read return strobes wrong");
  a_lp_hold:
    assert property (!rbf_n && !$past(rbf_n) |-> gnt_n || st != 3'h0) else $error("low read under rbf");
endmodule

// File: verif/test_agp_master_status_pipe_port.sv
// bench: both ends joined, plus a second device end driven by hand
`timescale 1ns/1ps
module test_agp_master_status_pipe_port;
  import agpsp_pkg::*;
  logic        clk_sys = 1'b0, clk2 = 1'b0, rst = 1'b1, rst_link = 1'b1;
  logic        rd_ret_valid = 1'b0, rd_ret_hi = 1'b0, wr_pend_valid = 1'b0, wr_pend_hi = 1'b0;
  logic        req_valid = 1'b0, rd_buf_full = 1'b0, req_valid2 = 1'b0;
  logic        rd_ret_take, wr_pend_take, wr_data_valid, wr_data_hi, enq_valid, dev_rbf;
  logic        req_ready, rd_valid, rd_hi, wr_taken, wr_taken_hi, owner, rsvd_seen;
  logic        rd_valid2, rsvd_seen2, wr_taken2, owner2;
  logic [31:0] rd_ret_data = 32'h0, req_addr = 32'h0, wr_data, enq_addr, rd_data, rd_data2;
  logic [31:0] wr_lo_data = 32'ha5a5_0f0f, wr_hi_data = 32'h5a5a_f0f0;
  logic [31:0] adr [3] = '{32'h0, 32'hffff_fffc, 32'h1234_5678};
  logic [31:0] enq_q [$];
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n_rd = 0, n_rd2 = 0, n_rs2 = 0, n_wt2 = 0;
  int          n_wt = 0, n_rs = 0;

  agpsp_if link ();
  agpsp_if link2 ();
  assign link2.agp_clk = clk2;
  always #4 clk_sys = ~clk_sys;
  always #24 clk2 = ~clk2;

  agpsp_host u_agpsp_host (.clk_sys, .rst, .link, .rd_ret_valid, .rd_ret_hi, .rd_ret_data,
    .rd_ret_take, .wr_pend_valid, .wr_pend_hi, .wr_pend_take, .wr_data, .wr_data_valid,
    .wr_data_hi, .enq_addr, .enq_valid, .dev_rbf);
  agpsp_dev u_agpsp_dev (.agp_clk(link.agp_clk), .rst(rst_link), .link, .req_valid, .req_addr,
    .req_ready, .rd_buf_full, .rd_data, .rd_valid, .rd_hi, .wr_lo_data, .wr_hi_data, .wr_taken,
    .wr_taken_hi, .owner, .rsvd_seen);
  // second end faces the bench, which plays the core logic and breaks its habits
  agpsp_dev u_agpsp_dev2 (.agp_clk(clk2), .rst(rst_link), .link(link2), .req_valid(req_valid2),
    .req_addr(32'h0), .req_ready(), .rd_buf_full(1'b0), .rd_data(rd_data2), .rd_valid(rd_valid2),
    .rd_hi(), .wr_lo_data(32'h0), .wr_hi_data(32'h0), .wr_taken(wr_taken2), .wr_taken_hi(),
    .owner(owner2), .rsvd_seen(rsvd_seen2));
  agpsp_checker u_agpsp_checker (.agp_clk(link.agp_clk), .rst(rst_link), .st(link.st),
    .gnt_n(link.gnt_n), .rbf_n(link.rbf_n), .pipe_o(link.pipe_o), .pipe_oe(link.pipe_oe),
    .ad_dev_oe(link.ad_dev_oe), .ad_host_oe(link.ad_host_oe), .stb_dev_oe(link.stb_dev_oe),
    .stb_dev_o(link.stb_dev_o), .stb(link.stb));

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // sample 1 ns after the last of the n edges so flop updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_on(ref logic s);
    int n;
    for (n = 0; n < 300 && s !== 1'b1; n++)
      step(1);
    check(n < 300, 1'b1);
  endtask

  task automatic rd_ret(input logic hi, input logic [31:0] d);
    rd_ret_valid = 1'b1;
    rd_ret_hi = hi;
    rd_ret_data = d;
    wait_on(rd_ret_take);
    rd_ret_valid = 1'b0;
    wait_on(rd_valid);
    check(rd_data, d);
    check(rd_hi, hi);
    step(12);
  endtask

  task automatic wr_req(input logic hi);
    wr_pend_valid = 1'b1;
    wr_pend_hi = hi;
    wait_on(wr_pend_take);
    wr_pend_valid = 1'b0;
    wait_on(wr_data_valid);
    check(wr_data, hi ? wr_hi_data : wr_lo_data);
    check({wr_data_hi, wr_taken_hi}, {hi, hi});
    step(12);
  endtask

  // bench in the core-logic role: one link period of the given grant and status, then idle
  task automatic drv2(input logic g_n, input logic [2:0] s, input logic [31:0] d);
    @(negedge clk2);
    #1;
    link2.gnt_n = g_n;
    link2.st = s;
    link2.ad_host_o = d;
    link2.ad_host_oe = 1'b1;
    link2.stb_host_o = 2'h3;
    link2.stb_host_oe = 1'b1;
    @(negedge clk2);
    #1;
    link2.gnt_n = 1'b1;
    link2.st = ST_IDLE_VAL;
    link2.ad_host_oe = 1'b0;
    link2.stb_host_o = STB_RST;
    link2.stb_host_oe = 1'b0;
    repeat (2) @(negedge clk2);
  endtask

  always @(posedge clk_sys) begin
    if (enq_valid === 1'b1)
      enq_q.push_back(enq_addr);
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  always @(posedge link.agp_clk) begin
    n_rd += int'(rd_valid === 1'b1);
    n_wt += int'(wr_taken === 1'b1);
    n_rs += int'(rsvd_seen === 1'b1);
  end

  always @(posedge clk2) begin
    n_rd2 += int'(rd_valid2 === 1'b1);
    n_rs2 += int'(rsvd_seen2 === 1'b1);
    n_wt2 += int'(wr_taken2 === 1'b1);
  end

  initial begin
    int n0;
    link2.gnt_n = 1'b1;
    link2.st = ST_IDLE_VAL;
    link2.ad_host_o = AD_RST;
    link2.ad_host_oe = 1'b0;
    link2.stb_host_o = STB_RST;
    link2.stb_host_oe = 1'b0;
    step(10);
    rst = 1'b0;
    step(40);
    rst_link = 1'b0;
    step(40);
    rd_ret(1'b0, 32'hffff_0001);
    rd_ret(1'b1, 32'h8000_7ffe);
    rd_buf_full = 1'b1;
    step(30);
    check({link.rbf_n, dev_rbf}, 2'h1);
    n0 = n_rd;
    rd_ret_valid = 1'b1;
    rd_ret_hi = 1'b0;
    step(60);
    check(n_rd, n0);
    rd_ret(1'b1, 32'h0f0f_f0f0);
    rd_buf_full = 1'b0;
    rd_ret(1'b0, 32'h1357_9bdf);
    wr_req(1'b0);
    wr_req(1'b1);
    check(n_wt, 2);
    // three addresses back to back, next offered as soon as one is taken
    @(posedge link.agp_clk);
    #1;
    foreach (adr[i]) begin
      req_valid = 1'b1;
      req_addr = adr[i];
      do @(negedge link.agp_clk); while (req_ready !== 1'b1);
      @(posedge link.agp_clk);
      #1;
    end
    req_valid = 1'b0;
    step(150);
    check(enq_q.size(), 3);
    foreach (adr[i]) check(enq_q[i], adr[i]);
    check({owner, link.pipe_n}, 2'h1);
    check({link.gnt_n, link.st}, {1'b1, ST_IDLE_VAL});
    check(n_rs, 0);
    req_valid2 = 1'b1;
    drv2(1'b1, ST_LP_READ, 32'hdead_beef);
    drv2(1'b1, ST_OWNER, 32'h0);
    check({n_rd2[0], owner2, link2.pipe_n}, 3'h1);
    req_valid2 = 1'b0;
    for (int c = 4; c < 7; c++)
      drv2(1'b0, 3'(c), 32'h0);
    check(n_rs2, 3);
    check(n_rd2 + n_wt2, 0);
    drv2(1'b0, ST_HP_READ, 32'hc3c3_3c3c);
    check(n_rd2, 1);
    check(rd_data2, 32'hc3c3_3c3c);
    end_sim();
  end
endmodule
